// >>> sysref_cfg_device.sv
/*
 * serial-port register bank: maker identification, user serial config,
 * sync clock control and the sysref edge position status.
 * assumes link inputs are synchronous to sys_clk_in; the host samples sdo
 * on the sclk rising edge and data is shifted msb first, 16-bit command
 * (read bit, 15-bit address) then bytes, streaming until cs_n rises.
 */
// Design decision made here: the plain strobed port.
// Overview of operation
// [R1] identification reads return a fixed code
// [R2] freeze clear: address steps in chosen direction
// [R3] freeze set: address stays constant when streaming
// [R4] host writes reserved fields with defaults
// [R5] receiver enable bit five switches receiver
// [R6] processor enable bit six allows sysref processing
// [R7] host enables receiver before processor
// [R8] fine window bit shrinks windowing steps
// [R9] host sets fine window at high rates
// [R10] four-bit delay choice selects sampling delay
// [R11] host picks delay from edge position
// [R12] clock control resets to 0x80
// [R13] user serial config resets to zero
// [R14] direction bit zero decrements, one increments
// [R15] 24-bit read-only edge position status
// [R16] writes to identification register are ignored
`timescale 1ns/1ps
`include "sysref_cfg_consts.svh"

module sysref_cfg_device
    import sysref_cfg_pkg::*;
#(
    // arbitrary neutral identification value
    parameter logic [15:0] MAKER_IDENT_CODE = 16'h5a3c
) (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    cfg_serial_if.device     link,
    input  wire logic [23:0] sysref_edge_position_in,
    output logic             sysref_receiver_enable_out,
    output logic             sysref_processor_enable_out,
    output logic             sysref_fine_window_out,
    output logic [3:0]       sysref_delay_choice_out
);

    ////////////////////////////////////////////////////////////////////////
    // link edge detection

    logic                  sclk_prev;
    logic                  sclk_rise;
    logic                  sclk_fall;
    dev_state_t            state;
    logic [3:0]            bit_cnt;
    logic [`CMD_W-1:0]     shift_in;
    logic                  is_read;
    logic [`ADDR_W-1:0]    addr;
    logic [`BYTE_W-1:0]    config_a;
    logic [`BYTE_W-1:0]    user_serial_config;
    logic [`BYTE_W-1:0]    sync_clock_control;
    logic [`BYTE_W-1:0]    rd_byte;
    logic [`BYTE_W-1:0]    next_byte;
    logic                  byte_done;
    logic                  cmd_done;
    logic [`ADDR_W-1:0]    next_addr;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sclk_prev <= 1'b0;
        end else begin
            sclk_prev <= link.sclk;
        end
    end

    assign sclk_rise = link.sclk & ~sclk_prev & ~link.cs_n;
    assign sclk_fall = ~link.sclk & sclk_prev & ~link.cs_n;
    assign next_byte = {shift_in[`BYTE_W-2:0], link.sdi};
    assign cmd_done  = sclk_rise && state == dev_cmd && bit_cnt == `CMD_CNT_LAST;
    assign byte_done = sclk_rise && state == dev_data && bit_cnt == `BIT_CNT_LAST;

    ////////////////////////////////////////////////////////////////////////
    // address stepping

    always_comb begin
        if (user_serial_config[`USR_FREEZE_BIT]) begin
            next_addr = addr;                                          // [R3]
        end else if (config_a[`CFGA_ASCEND_BIT]) begin
            next_addr = addr + `ADDR_STEP;                             // [R2] [R14]
        end else begin
            next_addr = addr - `ADDR_STEP;                             // [R2] [R14]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read multiplexer

    always_comb begin
        case (addr)
            `ADDR_CONFIG_A:        rd_byte = config_a | `CFGA_READ_SET;
            `ADDR_MAKER_IDENT_LO:  rd_byte = MAKER_IDENT_CODE[7:0];   // [R1]
            `ADDR_MAKER_IDENT_HI:  rd_byte = MAKER_IDENT_CODE[15:8];  // [R1]
            `ADDR_USER_SERIAL_CFG: rd_byte = user_serial_config;
            `ADDR_SYNC_CLOCK_CTRL: rd_byte = sync_clock_control;
            `ADDR_EDGE_POS_B0:     rd_byte = sysref_edge_position_in[7:0];   // [R15]
            `ADDR_EDGE_POS_B1:     rd_byte = sysref_edge_position_in[15:8];  // [R15]
            `ADDR_EDGE_POS_B2:     rd_byte = sysref_edge_position_in[23:16]; // [R15]
            default:               rd_byte = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // transfer sequencer

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state    <= dev_idle;
            bit_cnt  <= 4'h0;
            shift_in <= 16'h0000;
            is_read  <= 1'b0;
            addr     <= 15'h0000;
        end else if (link.cs_n) begin
            state   <= dev_idle;
            bit_cnt <= 4'h0;
        end else begin
            case (state)
                dev_idle: begin
                    state   <= dev_cmd;
                    bit_cnt <= 4'h0;
                end
                dev_cmd: begin
                    if (sclk_rise) begin
                        shift_in <= {shift_in[`CMD_W-2:0], link.sdi};
                        bit_cnt  <= bit_cnt + 4'h1;
                        if (cmd_done) begin
                            is_read <= shift_in[`CMD_W-2];
                            addr    <= {shift_in[`ADDR_W-2:0], link.sdi};
                            state   <= dev_data;
                            bit_cnt <= 4'h0;
                        end
                    end
                end
                dev_data: begin
                    if (sclk_rise) begin
                        shift_in <= {shift_in[`CMD_W-2:0], link.sdi};
                        if (byte_done) begin
                            bit_cnt <= 4'h0;
                            addr    <= next_addr;
                        end else begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                end
                default: begin
                    state <= dev_idle;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data shifter; loaded at command end and after each byte

    // the register mux still sees the old address in the cycle of the step,
    // so the load waits one cycle for the new address to settle
    logic load_pending;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            load_pending <= 1'b0;
        end else begin
            load_pending <= (cmd_done && shift_in[`CMD_W-2]) || (byte_done && is_read);
        end
    end

    logic [`BYTE_W-1:0] out_byte;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            out_byte <= 8'h00;
        end else if (link.cs_n) begin
            out_byte <= 8'h00;
        end else if (load_pending) begin
            out_byte <= rd_byte;
        end else if (sclk_fall && state == dev_data && bit_cnt != 4'h0) begin
            out_byte <= {out_byte[`BYTE_W-2:0], 1'b0};
        end
    end

    assign link.sdo = out_byte[`BYTE_W-1] & ~link.cs_n;

    ////////////////////////////////////////////////////////////////////////
    // register writes on each completed byte of a write stream

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            config_a           <= `RST_CONFIG_A;
            user_serial_config <= `RST_USER_SERIAL_CFG;                // [R13]
            sync_clock_control <= `RST_SYNC_CLOCK_CTRL;                // [R12]
        end else if (byte_done && !is_read) begin
            case (addr)
                `ADDR_CONFIG_A:        config_a <= next_byte & `CFGA_WRITE_MASK;
                `ADDR_USER_SERIAL_CFG: user_serial_config <= next_byte;
                `ADDR_SYNC_CLOCK_CTRL: sync_clock_control <= next_byte;
                default: begin
                    // identification, status and unmapped bytes drop here
                    config_a <= config_a;                              // [R16]
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sysref controls

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sysref_receiver_enable_out  <= 1'b0;
            sysref_processor_enable_out <= 1'b0;
            sysref_fine_window_out      <= 1'b0;
            sysref_delay_choice_out     <= 4'h0;
        end else begin
            sysref_receiver_enable_out  <= sync_clock_control[`CLK_RECV_BIT];  // [R5]
            // processing is only honoured behind a running receiver
            sysref_processor_enable_out <= sync_clock_control[`CLK_PROC_BIT]
                                         & sync_clock_control[`CLK_RECV_BIT]; // [R6] [R7]
            sysref_fine_window_out      <= sync_clock_control[`CLK_FINE_BIT];  // [R8]
            sysref_delay_choice_out     <=
                sync_clock_control[`CLK_SEL_MSB:`CLK_SEL_LSB];                 // [R10]
        end
    end

endmodule : sysref_cfg_device

// >>> sysref_cfg_consts.svh
/*
 * constants for the sysref and serial configuration register bank:
 * register addresses, field positions, reset values and transfer codes.
 * assumes it is included by bare name from the package and both ends.
 */
`ifndef SYSREF_CFG_CONSTS_SVH
`define SYSREF_CFG_CONSTS_SVH

`define ADDR_CONFIG_A          15'h0000
`define ADDR_MAKER_IDENT_LO    15'h000c
`define ADDR_MAKER_IDENT_HI    15'h000d
`define ADDR_USER_SERIAL_CFG   15'h0010
`define ADDR_SYNC_CLOCK_CTRL   15'h0029
`define ADDR_EDGE_POS_B0       15'h002c
`define ADDR_EDGE_POS_B1       15'h002d
`define ADDR_EDGE_POS_B2       15'h002e

`define RST_CONFIG_A           8'h30
`define RST_USER_SERIAL_CFG    8'h00
`define RST_SYNC_CLOCK_CTRL    8'h80

`define CFGA_ASCEND_BIT        5
`define CFGA_WRITE_MASK        8'hef
`define CFGA_READ_SET          8'h10
`define USR_FREEZE_BIT         0
`define CLK_RSVD_BIT           7
`define CLK_PROC_BIT           6
`define CLK_RECV_BIT           5
`define CLK_FINE_BIT           4
`define CLK_SEL_MSB            3
`define CLK_SEL_LSB            0

`define ADDR_STEP              15'h0001
`define ADDR_W                 15
`define BYTE_W                 8
`define CMD_W                  16
`define CMD_READ_BIT           15
`define BIT_CNT_LAST           4'h7
`define CMD_CNT_LAST           4'hf

`define HOST_ADDR_CMD_START    4'h0
`define HOST_ADDR_STATUS       4'h1
`define HOST_ADDR_RDATA        4'h2
`define HOST_CMD_GO_BIT        31
`define HOST_CMD_READ_BIT      30
`define HOST_CMD_LAST_BIT      29
`define HOST_CMD_ADDR_MSB      22
`define HOST_CMD_ADDR_LSB      8
`define HOST_SCLK_DIV_LAST     4'h3

`endif

// >>> sysref_cfg_pkg.sv
/*
 * types shared by the register bank and its serial host.
 * assumes the constants header sits in the same folder.
 */
`include "sysref_cfg_consts.svh"

package sysref_cfg_pkg;
    typedef enum logic [1:0] {
        dev_idle = 2'b00,
        dev_cmd  = 2'b01,
        dev_data = 2'b10
    } dev_state_t;

    typedef enum logic [1:0] {
        host_idle = 2'b00,
        host_cmd  = 2'b01,
        host_data = 2'b10,
        host_done = 2'b11
    } host_state_t;
endpackage : sysref_cfg_pkg

// >>> cfg_serial_if.sv
/*
 * serial configuration link between the host controller and the device.
 * assumes one shared system clock; sclk is a sampled level, not a clock.
 */
`timescale 1ns/1ps

interface cfg_serial_if;
    logic cs_n;
    logic sclk;
    logic sdi;
    logic sdo;

    modport device (input cs_n, input sclk, input sdi, output sdo);
    modport host   (output cs_n, output sclk, output sdi, input sdo);
endinterface : cfg_serial_if

// >>> sysref_cfg_host.sv
/*
 * serial host controller for the register bank; software drives it via
 * a small register port (command, status, read data).
 * assumes the device samples sdi on sclk rise and shifts sdo on sclk fall.
 */
`timescale 1ns/1ps
`include "sysref_cfg_consts.svh"

module sysref_cfg_host
    import sysref_cfg_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_write_in,
    input  wire logic        reg_read_in,
    output logic      [31:0] reg_rdata_out,
    cfg_serial_if.host       link
);

    ////////////////////////////////////////////////////////////////////////
    // command and sequencer

    host_state_t          state;
    logic [3:0]           div_cnt;
    logic                 tick;
    logic [3:0]           bit_cnt;
    logic [`CMD_W-1:0]    cmd_sh;
    logic [`BYTE_W-1:0]   data_sh;
    logic                 cs_hold;
    logic                 last_byte;
    logic                 busy;
    logic                 byte_ready;
    logic [`BYTE_W-1:0]   rx_byte;
    logic [`BYTE_W-1:0]   rx_sh;
    logic                 sclk_q;

    // host passes reserved fields through unchanged; software supplies
    // the full byte, so [R4], [R7], [R9], [R11] are left to software
    assign tick = (div_cnt == `HOST_SCLK_DIV_LAST);
    assign busy = (state != host_idle);

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_cnt <= 4'h0;
        end else if (!busy || tick) begin
            div_cnt <= 4'h0;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state      <= host_idle;
            sclk_q     <= 1'b0;
            bit_cnt    <= 4'h0;
            cmd_sh     <= 16'h0000;
            data_sh    <= 8'h00;
            last_byte  <= 1'b1;
            byte_ready <= 1'b0;
            rx_sh      <= 8'h00;
            rx_byte    <= 8'h00;
        end else begin
            case (state)
                host_idle: begin
                    if (reg_write_in && reg_addr_in == `HOST_ADDR_CMD_START
                        && reg_wdata_in[`HOST_CMD_GO_BIT]) begin
                        last_byte  <= reg_wdata_in[`HOST_CMD_LAST_BIT];
                        cmd_sh     <= {reg_wdata_in[`HOST_CMD_READ_BIT],
                                       reg_wdata_in[`HOST_CMD_ADDR_MSB:`HOST_CMD_ADDR_LSB]};
                        data_sh    <= reg_wdata_in[`BYTE_W-1:0];
                        bit_cnt    <= 4'h0;
                        byte_ready <= 1'b0;
                        // a stream in progress sends only the next byte
                        state      <= cs_hold ? host_data : host_cmd;
                    end
                end
                host_cmd: begin
                    if (tick) begin
                        sclk_q <= ~sclk_q;
                        if (sclk_q) begin
                            cmd_sh  <= {cmd_sh[`CMD_W-2:0], 1'b0};
                            bit_cnt <= bit_cnt + 4'h1;
                            if (bit_cnt == `CMD_CNT_LAST) begin
                                bit_cnt <= 4'h0;
                                state   <= host_data;
                            end
                        end
                    end
                end
                host_data: begin
                    if (tick) begin
                        sclk_q <= ~sclk_q;
                        if (!sclk_q) begin
                            rx_sh <= {rx_sh[`BYTE_W-2:0], link.sdo};
                        end else begin
                            data_sh <= {data_sh[`BYTE_W-2:0], 1'b0};
                            bit_cnt <= bit_cnt + 4'h1;
                            if (bit_cnt == `BIT_CNT_LAST) begin
                                rx_byte    <= rx_sh;
                                byte_ready <= 1'b1;
                                bit_cnt    <= 4'h0;
                                state      <= last_byte ? host_done : host_idle;
                            end
                        end
                    end
                end
                host_done: begin
                    state <= host_idle;
                end
                default: begin
                    state <= host_idle;
                end
            endcase
            // next byte of a stream continues without releasing chip select
            if (state == host_data && tick && sclk_q && bit_cnt == `BIT_CNT_LAST
                && !last_byte) begin
                state <= host_idle;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pins: chip select held through a stream until the last byte ends

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cs_hold <= 1'b0;
        end else if (state == host_cmd) begin
            cs_hold <= 1'b1;
        end else if (state == host_done) begin
            cs_hold <= 1'b0;
        end
    end

    assign link.cs_n = ~(cs_hold || state == host_cmd || state == host_data);
    assign link.sclk = sclk_q;
    assign link.sdi  = (state == host_cmd) ? cmd_sh[`CMD_W-1] : data_sh[`BYTE_W-1];

    ////////////////////////////////////////////////////////////////////////
    // register read port

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 32'h0000_0000;
        end else if (reg_read_in) begin
            case (reg_addr_in)
                `HOST_ADDR_STATUS: reg_rdata_out <= {30'h0, byte_ready, busy};
                `HOST_ADDR_RDATA:  reg_rdata_out <= {24'h0, rx_byte};
                default:           reg_rdata_out <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_out <= 32'h0000_0000;
        end
    end

endmodule : sysref_cfg_host

// >>> cfg_link_sva.sv
/*
 * wire checks for the serial configuration link between host and device.
 * assumes one system clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps

module cfg_link_sva (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sdo
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    logic       sclk_q;
    logic [7:0] rises;

    // counts sclk rises per frame so whole-byte framing can be judged
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sclk_q <= 1'b0;
            rises  <= 8'h00;
        end else begin
            sclk_q <= sclk;
            if (cs_n) begin
                rises <= 8'h00;
            end else if (sclk && !sclk_q) begin
                rises <= rises + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    idle_clock_a: assert property (cs_n |-> !sclk)
        else $error("sclk high while deselected");
    idle_data_a: assert property (cs_n |-> !sdo)
        else $error("sdo driven while deselected");
    high_phase_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
        else $error("sclk high phase not four cycles");
    low_phase_a: assert property ($fell(sclk) |-> !sclk [*4])
        else $error("sclk low phase too short");
    select_clean_a: assert property ($fell(cs_n) |-> !sclk)
        else $error("select fell with sclk high");
    first_pulse_a: assert property ($fell(cs_n) |-> ##[1:12] $rose(sclk))
        else $error("no sclk pulse after select");
    frame_bytes_a: assert property ($rose(cs_n) |-> rises >= 8'h18 && rises[2:0] == 3'h0)
        else $error("frame not command plus whole bytes");
    deselect_low_a: assert property ($rose(cs_n) |-> !$past(sclk))
        else $error("deselect while sclk high");
    data_setup_a: assert property (sclk && $past(sclk) |-> $stable(sdi))
        else $error("sdi moved while sclk high");

    ////////////////////////////////////////////////////////////////////////
    single_cv: cover property ($rose(cs_n) && rises == 8'h18);
    stream_cv: cover property ($rose(cs_n) && rises == 8'h28);
    select_cv: cover property ($fell(cs_n));
endmodule : cfg_link_sva

// >>> tb_sysref_and_serial_cfg_regs.sv
/*
 * self-checking bench: host and register bank joined by the link.
 * assumes the constants header and package are compiled first.
 */
`timescale 1ns/1ps
`include "sysref_cfg_consts.svh"

module tb_sysref_and_serial_cfg_regs;
    import sysref_cfg_pkg::*;
    // arbitrary identification value
    localparam logic [15:0] IDENT = 16'h3c96;

    logic        sys_clk_in;
    logic        rst_n_in;
    logic [3:0]  reg_addr_in;
    logic [31:0] reg_wdata_in;
    logic        reg_write_in;
    logic        reg_read_in;
    logic [31:0] reg_rdata_out;
    logic [23:0] sysref_edge_position_in;
    logic        recv;
    logic        proc;
    logic        fine;
    logic [3:0]  choice;
    int          errors;
    int          n_checks;

    cfg_serial_if link ();
    sysref_cfg_host u_sysref_cfg_host (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
        .reg_rdata_out(reg_rdata_out), .link(link));
    sysref_cfg_device #(.MAKER_IDENT_CODE(IDENT)) u_sysref_cfg_device (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .link(link),
        .sysref_edge_position_in(sysref_edge_position_in),
        .sysref_receiver_enable_out(recv), .sysref_processor_enable_out(proc),
        .sysref_fine_window_out(fine), .sysref_delay_choice_out(choice));
    cfg_link_sva u_cfg_link_sva (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .cs_n(link.cs_n), .sclk(link.sclk), .sdi(link.sdi), .sdo(link.sdo));

    always #5 sys_clk_in = ~sys_clk_in;

    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_write_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_read_in <= 1'b0;
        #1;
        d = reg_rdata_out;
    endtask : rd

    // one byte over the link; a stream keeps select low until last is set
    task automatic xfer(input logic r, input logic l, input logic [14:0] a,
                        input logic [7:0] wd, output logic [7:0] rx);
        logic [31:0] s;
        wr(`HOST_ADDR_CMD_START, {1'b1, r, l, 6'h00, a, wd});
        s = 32'h1;
        for (int i = 0; i < 400 && s[0] !== 1'b0; i++) begin
            rd(`HOST_ADDR_STATUS, s);
        end
        if (s[0] !== 1'b0) begin
            chk(s, 32'h0);
            summarize();
        end
        // idle with the byte flag raised
        chk(s, 32'h2);
        rd(`HOST_ADDR_RDATA, s);
        rx = s[7:0];
    endtask : xfer

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [7:0] rx;
        chk({recv, proc, fine, choice}, 32'h0);
        xfer(1'b1, 1'b1, `ADDR_SYNC_CLOCK_CTRL, 8'h00, rx);
        chk(rx, 32'h80);
        xfer(1'b1, 1'b1, `ADDR_USER_SERIAL_CFG, 8'h00, rx);
        chk(rx, 32'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_ident();
        logic [7:0] rx;
        xfer(1'b0, 1'b1, `ADDR_MAKER_IDENT_LO, ~IDENT[7:0], rx);
        xfer(1'b1, 1'b0, `ADDR_MAKER_IDENT_LO, 8'h00, rx);
        chk(rx, IDENT[7:0]);
        xfer(1'b1, 1'b1, 15'h0000, 8'h00, rx);
        chk(rx, IDENT[15:8]);
        xfer(1'b1, 1'b1, `ADDR_SYNC_CLOCK_CTRL, 8'h00, rx);
        chk(rx, 32'h80);
        $display("test ident done");
    endtask : t_ident

    task automatic t_clock();
        logic [7:0] rx;
        logic [7:0] v [5] = '{8'ha0, 8'he0, 8'hff, 8'h9a, 8'h80};
        // receiver goes on before the processor, reserved top bit kept at one
        for (int i = 0; i < 5; i++) begin
            xfer(1'b0, 1'b1, `ADDR_SYNC_CLOCK_CTRL, v[i], rx);
            chk({recv, proc, fine, choice}, {v[i][5], v[i][6], v[i][4], v[i][3:0]});
            xfer(1'b1, 1'b1, `ADDR_SYNC_CLOCK_CTRL, 8'h00, rx);
            chk(rx, v[i]);
        end
        $display("test clock control done");
    endtask : t_clock

    task automatic t_stream();
        logic [7:0] rx;
        xfer(1'b0, 1'b1, `ADDR_CONFIG_A, 8'h00, rx);
        xfer(1'b1, 1'b0, `ADDR_MAKER_IDENT_HI, 8'h00, rx);
        chk(rx, IDENT[15:8]);
        xfer(1'b1, 1'b1, 15'h0000, 8'h00, rx);
        chk(rx, IDENT[7:0]);
        xfer(1'b0, 1'b1, `ADDR_CONFIG_A, 8'h20, rx);
        xfer(1'b1, 1'b0, `ADDR_EDGE_POS_B0, 8'h00, rx);
        chk(rx, 32'h12);
        xfer(1'b1, 1'b0, 15'h0000, 8'h00, rx);
        chk(rx, 32'ha5);
        xfer(1'b1, 1'b1, 15'h0000, 8'h00, rx);
        chk(rx, 32'hc3);
        // with the address held both stream bytes land on clock control
        xfer(1'b0, 1'b1, `ADDR_USER_SERIAL_CFG, 8'h01, rx);
        xfer(1'b0, 1'b0, `ADDR_SYNC_CLOCK_CTRL, 8'ha3, rx);
        xfer(1'b0, 1'b1, 15'h0000, 8'hb6, rx);
        chk({recv, proc, fine, choice}, 32'h56);
        xfer(1'b1, 1'b0, `ADDR_USER_SERIAL_CFG, 8'h00, rx);
        chk(rx, 32'h01);
        xfer(1'b1, 1'b1, 15'h0000, 8'h00, rx);
        chk(rx, 32'h01);
        xfer(1'b0, 1'b1, `ADDR_USER_SERIAL_CFG, 8'h00, rx);
        xfer(1'b1, 1'b1, `ADDR_SYNC_CLOCK_CTRL, 8'h00, rx);
        chk(rx, 32'hb6);
        $display("test streaming done");
    endtask : t_stream

    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk_in = 1'b0;
        rst_n_in = 1'b0;
        reg_addr_in = 4'h0;
        reg_wdata_in = 32'h0;
        reg_write_in = 1'b0;
        reg_read_in = 1'b0;
        sysref_edge_position_in = 24'hc3a512;
        errors = 0;
        n_checks = 0;
        repeat (3) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        t_reset();
        t_ident();
        t_clock();
        t_stream();
        summarize();
    end
endmodule : tb_sysref_and_serial_cfg_regs
